// File: design/msc_params.svh
// Constants of the measurement sync and interrupt control block.
// Assumes inclusion by bare name from the package and the design.
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

// ==========================================================
// Register byte offsets on APB
`define MSC_A_CTRL   8'h00
`define MSC_A_STAT   8'h04
`define MSC_A_INT0   8'h08
`define MSC_A_INT1   8'h0C
`define MSC_A_ISET   8'h10
`define MSC_A_IRST   8'h14

// ==========================================================
// Control register bit positions and reset value
`define MSC_B_IDLE   0
`define MSC_B_SYNC   1
`define MSC_B_LMODE  2
`define MSC_B_LRST   4
`define MSC_B_LPORT  5
`define MSC_B_BLK    6
`define MSC_B_FIRST  7
`define MSC_B_FSYNC  8
`define MSC_B_DSYNC  9
`define MSC_CTRL_RST 32'h00000090

// ==========================================================
// Interrupt setup word: mask 0xMM00, line, generator select
`define MSC_F_LINE   16
`define MSC_F_GSEL   20

// ==========================================================
// Status bit positions
`define MSC_S_PASS   2
`define MSC_S_CMPL   7
`define MSC_S_ARMED  10

// ==========================================================
// Timing: ADC sample clock derived from pclk
`define MSC_PCLK_NS       5
`define MSC_ADC_NS        50
`define MSC_ADC_DIV       (`MSC_ADC_NS / `MSC_PCLK_NS)
`define MSC_SYNC_HOLD_ADC 8
`define MSC_LB_W          32

`endif

// File: design/msc_pkg.sv
// Types of the measurement sync and interrupt control block.
// Assumes msc_params.svh is on the include path.
`include "msc_params.svh"

package msc_pkg;

  // ========================================================
  // Measurement loop states, codes as seen in status
  typedef enum logic [1:0] {
    MSC_IDLE = 2'b00,
    MSC_ARM  = 2'b01,
    MSC_MEAS = 2'b10,
    MSC_TRIG = 2'b11
  } msc_state_e;

  // ========================================================
  // All state of the control block
  typedef struct packed {
    msc_state_e             st;
    logic                   idle_f;
    logic                   sync_c;
    logic [1:0]             lmode;
    logic                   lrst;
    logic                   lport;
    logic                   blk;
    logic                   first;
    logic                   fsync;
    logic                   dsync;
    logic [1:0][7:0]        mask;
    logic [1:0][7:0]        saved;
    logic [1:0][2:0]        line;
    logic [2:0]             sy;
    logic                   sstab;
    logic [3:0]             div;
    logic [3:0]             hold;
    logic                   pend;
    logic                   hs;
    logic                   cmpl;
    logic                   drv;
    logic                   phase;
    logic                   dn_v;
    logic                   dn_l;
    logic [`MSC_LB_W-1:0]   dn_d;
    logic [31:0]            rdata;
    logic                   lo_ld;
    logic                   dec_rs;
  } msc_regs_s;

endpackage

// File: design/msc_ctrl.sv
// Measurement sync, interrupt and local bus control of a digitizer.
// Assumes an APB master on pclk, same-clock status and stream
// logic around it, and an open-drain SYNC wire resolved outside.
`timescale 1ns/10ps
`include "msc_params.svh"

module msc_ctrl (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [7:0]           stat_hi_i,
  input  wire logic                 pretrig_ok_i,
  input  wire logic                 trig_i,
  input  wire logic                 block_done_i,
  input  wire logic                 fifo_ovf_i,
  input  wire logic                 peers_idle_i,
  input  wire logic [1:0]           irq_ack_i,
  output logic [1:0]                irq_req_o,
  output logic [2:0]                irq_line0_o,
  output logic [2:0]                irq_line1_o,
  input  wire logic                 sync_i,
  output logic                      sync_o,
  output logic                      sync_oe_n,
  output logic                      lo_load_o,
  output logic                      dec_rst_o,
  output logic [1:0]                meas_state_o,
  output logic                      lbus_rst_o,
  input  wire logic                 up_valid,
  output logic                      up_ready,
  input  wire logic [`MSC_LB_W-1:0] up_data,
  input  wire logic                 up_last,
  input  wire logic                 loc_valid,
  output logic                      loc_ready,
  input  wire logic [`MSC_LB_W-1:0] loc_data,
  input  wire logic                 loc_last,
  output logic                      dn_valid,
  input  wire logic                 dn_ready,
  output logic [`MSC_LB_W-1:0]      dn_data,
  output logic                      dn_last
);

  // ========================================================
  // Declarations
  localparam logic [3:0] ADC_DIV  = 4'(`MSC_ADC_DIV);
  localparam logic [3:0] HOLD_ADC = 4'(`MSC_SYNC_HOLD_ADC);

  msc_pkg::msc_regs_s r;
  msc_pkg::msc_regs_s n;
  logic               acc;
  logic               wr;
  logic               err;
  logic [1:0]         gsel;
  logic               adc_ce;
  logic               armed;
  logic [7:0]         shi;
  logic               s_rise;
  logic               s_fall;
  logic               usr;
  logic               src_loc;
  logic               can_load;
  logic               take;
  logic               tlast;

  // Address is in the map
  function automatic logic hit(input logic [7:0] a);
    hit = (a == `MSC_A_CTRL) || (a == `MSC_A_STAT) ||
          (a == `MSC_A_INT0) || (a == `MSC_A_INT1) ||
          (a == `MSC_A_ISET) || (a == `MSC_A_IRST);
  endfunction

  // ========================================================
  // Bus answer: zero wait, error on unmapped or bad setup
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign gsel   = pwdata[`MSC_F_GSEL+:2];
  assign pready = 1'b1;
  assign err = acc & (!hit(paddr) || (pwrite && paddr == `MSC_A_ISET &&
               (gsel > 2'd1 || pwdata[7:0] != 8'h00)));
  assign pslverr = err;
  assign prdata  = r.rdata;

  // ========================================================
  // Status and interrupt requests
  // armed in trigger, or in arm when pre-trigger met
  assign armed = (r.st == msc_pkg::MSC_TRIG) ||
                 (r.st == msc_pkg::MSC_ARM && pretrig_ok_i);
  assign shi   = {stat_hi_i[7:3], armed, stat_hi_i[1:0]};
  // line zero disables, masked upper status
  assign irq_req_o[0] = (r.line[0] != 3'h0) && |(shi & r.mask[0]);
  assign irq_req_o[1] = (r.line[1] != 3'h0) && |(shi & r.mask[1]);
  assign irq_line0_o  = r.line[0];
  assign irq_line1_o  = r.line[1];

  // ========================================================
  // Pins and pulses, all from flip-flops but the tied-low sync_o
  // open drain: only ever pull low
  assign sync_o       = 1'b0;
  assign sync_oe_n    = !r.drv;
  assign lo_load_o    = r.lo_ld;
  assign dec_rst_o    = r.dec_rs;
  assign meas_state_o = r.st;
  assign lbus_rst_o   = r.lrst;
  assign dn_valid     = r.dn_v;
  assign dn_data      = r.dn_d;
  assign dn_last      = r.dn_l;

  // ========================================================
  // Local bus source select and handshakes
  // source by mode and phase
  always_comb begin
    case (r.lmode)
      2'd0:    src_loc = 1'b0;
      2'd1:    src_loc = 1'b1;
      2'd2:    src_loc = r.phase;
      default: src_loc = !r.phase;
    endcase
  end
  // only on local bus port and out of reset
  assign can_load  = r.lport & !r.lrst & (!r.dn_v | dn_ready);
  assign up_ready  = can_load & !src_loc;
  assign loc_ready = can_load & src_loc;
  assign take  = src_loc ? (loc_valid & loc_ready) : (up_valid & up_ready);
  assign tlast = src_loc ? loc_last : up_last;

  // ========================================================
  // Next state
  always_comb begin
    n        = r;
    n.lo_ld  = 1'b0;
    n.dec_rs = 1'b0;
    // ADC sample rate enable
    adc_ce = (r.div == ADC_DIV - 4'h1);
    n.div  = adc_ce ? 4'h0 : r.div + 4'h1;

    // SYNC wire: third and second stages must agree
    n.sy = {r.sy[1:0], sync_i};
    if (r.sy[1] == r.sy[2]) begin
      n.sstab = r.sy[2];
    end
    s_rise = r.sstab & !n.sstab;
    s_fall = !r.sstab & n.sstab;

    // Read data captured in the setup phase
    if (psel && !penable) begin
      if (paddr == `MSC_A_CTRL) begin
        n.rdata = {22'h0, r.dsync, r.fsync, r.first, r.blk, r.lport,
                   r.lrst, r.lmode, r.sync_c, r.idle_f};
      end else if (paddr == `MSC_A_STAT) begin
        n.rdata = {16'h0, shi, r.cmpl, 4'h0, 1'b1, r.st};
      end else if (paddr == `MSC_A_INT0) begin
        n.rdata = {16'h0, r.mask[0], 5'h0, r.line[0]};
      end else if (paddr == `MSC_A_INT1) begin
        n.rdata = {16'h0, r.mask[1], 5'h0, r.line[1]};
      end else begin
        n.rdata = 32'h0;
      end
    end

    for (int g = 0; g < 2; g++) begin
      if (irq_ack_i[g]) begin
        n.mask[g] = 8'h00;
      end
    end

    // Hold timer runs in ADC cycles; completion set after the hold
    if (r.pend && adc_ce) begin
      n.hold = r.hold - 4'h1;
      if (r.hold == 4'h1) begin
        n.pend = 1'b0;
        n.hs   = 1'b0;
      end
    end

    // Register writes
    if (wr && !err) begin
      if (paddr == `MSC_A_CTRL) begin
        n.idle_f = pwdata[`MSC_B_IDLE];
        n.sync_c = pwdata[`MSC_B_SYNC];
        n.lmode  = pwdata[`MSC_B_LMODE+:2];
        n.lrst   = pwdata[`MSC_B_LRST];
        n.lport  = pwdata[`MSC_B_LPORT];
        n.blk    = pwdata[`MSC_B_BLK];
        n.first  = pwdata[`MSC_B_FIRST];
        n.fsync  = pwdata[`MSC_B_FSYNC];
        n.dsync  = pwdata[`MSC_B_DSYNC];
        // user change restarts the propagation hold
        if (pwdata[`MSC_B_IDLE] != r.idle_f ||
            pwdata[`MSC_B_SYNC] != r.sync_c) begin
          n.pend = 1'b1;
          n.hold = HOLD_ADC;
          n.cmpl = 1'b0;
          // Hold survives a release written before it runs out
          n.hs   = r.hs | (pwdata[`MSC_B_SYNC] & !r.sync_c);
        end
      end else if (paddr == `MSC_A_ISET) begin
        // program line and upper mask byte
        n.mask[gsel[0]]  = pwdata[15:8];
        n.saved[gsel[0]] = pwdata[15:8];
        n.line[gsel[0]]  = pwdata[`MSC_F_LINE+:3];
      end else if (paddr == `MSC_A_IRST && pwdata[0]) begin
        n.mask = r.saved;
      end
    end

    // completion wins over a clear in the same cycle
    if (r.pend && adc_ce && r.hold == 4'h1) begin
      n.cmpl = 1'b1;
    end

    // Measurement loop
    case (r.st)
      msc_pkg::MSC_IDLE: begin
        if (s_rise && (!r.blk || peers_idle_i)) begin
          n.st     = msc_pkg::MSC_ARM;
          n.lo_ld  = 1'b1;
          n.dec_rs = r.dsync;
        end
      end
      msc_pkg::MSC_ARM: begin
        if (s_fall) begin
          n.st = msc_pkg::MSC_TRIG;
        end
      end
      msc_pkg::MSC_TRIG: begin
        if (trig_i) begin
          n.st = msc_pkg::MSC_MEAS;
        end
      end
      default: begin
        if (r.blk) begin
          // shared release ends the block together
          if (s_fall) begin
            n.st = msc_pkg::MSC_IDLE;
          end
        end else if (fifo_ovf_i) begin
          n.st = msc_pkg::MSC_IDLE;
        end else if (s_rise) begin
          n.lo_ld  = r.fsync;
          n.dec_rs = r.dsync;
        end
      end
    endcase
    if (r.idle_f) begin
      n.st = msc_pkg::MSC_IDLE;
    end

    usr   = r.sync_c | r.hs;
    n.drv = r.first & (usr |
            (r.st == msc_pkg::MSC_ARM && !pretrig_ok_i) |
            (r.st == msc_pkg::MSC_MEAS && r.blk && !block_done_i));

    // output stage of the local bus
    if (r.lrst) begin
      n.dn_v  = 1'b0;
      n.phase = 1'b0;
    end else begin
      if (r.dn_v && dn_ready) begin
        n.dn_v = 1'b0;
      end
      if (take) begin
        n.dn_v = 1'b1;
        n.dn_d = src_loc ? loc_data : up_data;
        n.dn_l = tlast;
        // Frame boundary swaps source in append and insert modes
        if (tlast && r.lmode[1]) begin
          n.phase = !r.phase;
        end
      end
    end
  end

  // ========================================================
  // State register; reset gives the documented defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r       <= '0;
      r.lrst  <= 1'b1;
      r.first <= 1'b1;
      r.sy    <= 3'b111;
      r.sstab <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_user_sync;
    wr && paddr == `MSC_A_CTRL && pwdata[`MSC_B_SYNC] && !r.sync_c &&
    pwdata[`MSC_B_FIRST];
  endsequence

  chk_sel_reject: assert property (
    wr && paddr == `MSC_A_ISET && gsel > 2'd1 |-> pslverr ##1
    ($stable(r.saved) && $stable(r.line))) else $error("bad generator select accepted");

  chk_line_off: assert property (
    r.line[0] == 3'h0 |-> !irq_req_o[0])
    else $error("interrupt with line zero");

  chk_ack_clear: assert property (
    irq_ack_i[1] && !(wr && (paddr == `MSC_A_IRST || paddr == `MSC_A_ISET))
    |=> r.mask[1] == 8'h00
    && !irq_req_o[1]) else $error("ack did not clear mask");

  chk_restore_mask: assert property (
    wr && paddr == `MSC_A_IRST && pwdata[0] && irq_ack_i == 2'b00
    |=> r.mask == $past(r.saved)) else $error("restore failed");

  chk_lbus_hold: assert property (
    r.lrst |-> !up_ready && !loc_ready ##1 !dn_valid)
    else $error("local bus active in reset");

  chk_force_idle: assert property (
    r.idle_f |=> meas_state_o == 2'b00)
    else $error("forced idle not honoured");

  chk_sync_hold: assert property (
    s_user_sync |=> ##1 !sync_oe_n [*8])
    else $error("sync released too early");

  chk_cont_release: assert property (
    r.st == msc_pkg::MSC_MEAS && !r.blk && !r.sync_c && !r.hs
    |=> sync_oe_n) else $error("sync driven in continuous measure");

  chk_ovf_idle: assert property (
    r.st == msc_pkg::MSC_MEAS && !r.blk && fifo_ovf_i
    |=> r.st == msc_pkg::MSC_IDLE) else $error("overflow kept measuring");

  chk_chassis: assert property (
    !r.first |=> sync_oe_n) else $error("non-first chassis drove sync");

endmodule

// File: tb/msc_peer.sv
// Far side model: other modules on the shared SYNC wire and the
// upstream neighbour on the local bus. Assumes one pclk domain.
`timescale 1ns/10ps
`include "msc_params.svh"

module msc_peer (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 sync_oe_n,
  input  wire logic                 peer_hold,
  input  wire logic                 up_ready,
  output logic                      sync_w,
  output logic                      up_valid,
  output logic                      up_last,
  output logic [`MSC_LB_W-1:0]      up_data
);
  logic [15:0] cnt_ff;

  // ==========================================================
  // Shared SYNC wire
  // wired open drain
  // Pull-up wins only when no party pulls low
  assign sync_w = sync_oe_n & ~peer_hold;

  // ==========================================================
  // Upstream neighbour: one-beat frames, held until taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0;
    end else if (up_valid && up_ready) begin
      cnt_ff <= cnt_ff + 16'h1;
    end
  end

  // Upper half marks the source so mixing shows at the output
  assign up_valid = presetn;
  assign up_last  = 1'b1;
  assign up_data  = {16'hAAAA, cnt_ff};
endmodule

// File: tb/test_msc_ctrl.sv
// Self-checking bench of the sync, interrupt and local bus control.
// Assumes msc_peer stands for the SYNC peers and the upstream module.
`timescale 1ns/10ps
`include "msc_params.svh"

module test_msc_ctrl;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } msc_row_s;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        pretrig_ok_i, trig_i, block_done_i, fifo_ovf_i, peers_idle_i;
  logic        sync_w, sync_o, sync_oe_n, lo_load_o, dec_rst_o, lbus_rst_o;
  logic        up_valid, up_ready, up_last, loc_valid, loc_ready, loc_last;
  logic        dn_valid, dn_ready, dn_last, lo_seen, dec_seen, peer_hold;
  logic [1:0]  irq_ack_i, irq_req_o, meas_state_o;
  logic [2:0]  irq_line0_o, irq_line1_o;
  logic [7:0]  paddr, stat_hi_i;
  logic [15:0] src;
  logic [31:0] pwdata, prdata, up_data, loc_data, dn_data, rd, m;
  int          fail_count, checks, i;

  // ==========================================================
  // Register cases: address, write, data, expected read, error
  localparam msc_row_s ROWS [12] = '{
    '{8'h00, 1'b0, 32'h0, 32'h90, 1'b0},
    '{8'h04, 1'b0, 32'h0, 32'h4, 1'b0},
    '{8'h08, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h0C, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h10, 1'b1, 32'h0005AB00, 32'h0, 1'b0},
    '{8'h10, 1'b1, 32'h00171200, 32'h0, 1'b0},
    '{8'h10, 1'b1, 32'h00230000, 32'h0, 1'b1},
    '{8'h10, 1'b1, 32'h00030001, 32'h0, 1'b1},
    '{8'h10, 1'b1, 32'h00330000, 32'h0, 1'b1},
    '{8'h08, 1'b0, 32'h0, 32'h0000AB05, 1'b0},
    '{8'h0C, 1'b0, 32'h0, 32'h00001207, 1'b0},
    '{8'h18, 1'b0, 32'h0, 32'h0, 1'b1}
  };

  msc_ctrl msc_ctrl_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .stat_hi_i, .pretrig_ok_i, .trig_i, .block_done_i,
    .fifo_ovf_i, .peers_idle_i, .irq_ack_i, .irq_req_o, .irq_line0_o, .irq_line1_o,
    .sync_i(sync_w), .sync_o, .sync_oe_n, .lo_load_o, .dec_rst_o, .meas_state_o,
    .lbus_rst_o, .up_valid, .up_ready, .up_data, .up_last, .loc_valid, .loc_ready,
    .loc_data, .loc_last, .dn_valid, .dn_ready, .dn_data, .dn_last);

  msc_peer msc_peer_i (.pclk, .presetn, .sync_oe_n, .peer_hold, .up_ready,
    .sync_w, .up_valid, .up_last, .up_data);

  // Clock of 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Pulses are one cycle wide, so keep a sticky copy
  always @(posedge pclk) begin
    if (lo_load_o === 1'b1) lo_seen <= 1'b1;
    if (dec_rst_o === 1'b1) dec_seen <= 1'b1;
  end

  task chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask

  task complete_run;
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task hang;
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run;
  endtask

  // APB transfer; request held until pready is seen high
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) hang;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_st(input logic [1:0] s);
    int k;
    for (k = 0; k < 200; k++) begin
      @(negedge pclk);
      if (meas_state_o === s) break;
    end
    if (k == 200) hang;
    // Hand back on a rising edge so the next drive lands there
    @(posedge pclk);
  endtask

  // Collect two downstream beats and compare their source marks
  task beats(input logic [15:0] e0, input logic [15:0] e1);
    int          k;
    int          n;
    logic [15:0] got [2];
    n = 0;
    for (k = 0; k < 20 && n < 2; k++) begin
      @(negedge pclk);
      if (dn_valid === 1'b1) begin
        got[n] = dn_data[31:16];
        n++;
      end
    end
    if (n < 2) hang;
    chk({16'h0, got[0]}, {16'h0, e0});
    chk({16'h0, got[1]}, {16'h0, e1});
    chk({31'h0, dn_last}, 32'h1);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, pretrig_ok_i, trig_i, block_done_i} = 7'h0;
    {fifo_ovf_i, peers_idle_i, peer_hold, lo_seen, dec_seen} = 5'h0;
    {paddr, pwdata, stat_hi_i, irq_ack_i} = 50'h0;
    {loc_valid, loc_last, dn_ready} = 3'h7;
    loc_data = 32'h55550000;
    repeat (5) @(posedge pclk);
    chk({28'h0, lbus_rst_o, sync_oe_n, meas_state_o}, 32'hC);
    presetn <= 1'b1;
    foreach (ROWS[k]) begin
      apb(ROWS[k].a, ROWS[k].w, ROWS[k].d);
      chk({31'h0, er}, {31'h0, ROWS[k].e});
      if (!ROWS[k].w) chk(rd, ROWS[k].x);
    end
    // Interrupt request, acknowledge and restore
    stat_hi_i <= 8'h08;
    repeat (2) @(negedge pclk);
    chk({26'h0, irq_line1_o, irq_line0_o}, 32'h3D);
    chk({30'h0, irq_req_o}, 32'h1);
    @(posedge pclk);
    irq_ack_i <= 2'b11;
    @(posedge pclk);
    irq_ack_i <= 2'b00;
    @(negedge pclk);
    chk({30'h0, irq_req_o}, 32'h0);
    apb(8'h08, 1'b0, 32'h0);
    chk(rd, 32'h5);
    apb(8'h14, 1'b1, 32'h1);
    apb(8'h08, 1'b0, 32'h0);
    chk(rd, 32'hAB05);
    apb(8'h10, 1'b1, 32'h00100800);
    @(negedge pclk);
    chk({30'h0, irq_req_o}, 32'h1);
    @(posedge pclk);
    stat_hi_i <= 8'h00;
    // Sync from idle with oscillator and filter sync requested
    apb(8'h00, 1'b1, 32'h392);
    for (i = 0; i < 10 && sync_oe_n !== 1'b0; i++) @(negedge pclk);
    chk({30'h0, sync_o, sync_oe_n}, 32'h0);
    wait_st(2'b01);
    repeat (2) @(negedge pclk);
    chk({30'h0, dec_seen, lo_seen}, 32'h3);
    apb(8'h00, 1'b1, 32'h390);
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h5);
    repeat (120) @(posedge pclk);
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h85);
    pretrig_ok_i <= 1'b1;
    wait_st(2'b11);
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h487);
    trig_i <= 1'b1;
    wait_st(2'b10);
    trig_i <= 1'b0;
    pretrig_ok_i <= 1'b0;
    repeat (4) @(negedge pclk);
    chk({31'h0, sync_oe_n}, 32'h1);
    lo_seen = 1'b0;
    peer_hold <= 1'b1;
    repeat (10) @(posedge pclk);
    peer_hold <= 1'b0;
    repeat (6) @(negedge pclk);
    chk({29'h0, lo_seen, meas_state_o}, 32'h6);
    @(posedge pclk);
    fifo_ovf_i <= 1'b1;
    wait_st(2'b00);
    fifo_ovf_i <= 1'b0;
    // Forced idle from arm, then refused syncs
    apb(8'h00, 1'b1, 32'h92);
    wait_st(2'b01);
    apb(8'h00, 1'b1, 32'h91);
    wait_st(2'b00);
    apb(8'h00, 1'b1, 32'hD0);
    // Let the sync hold run out so the next assert is a fresh edge
    repeat (120) @(posedge pclk);
    apb(8'h00, 1'b1, 32'hD2);
    repeat (30) @(negedge pclk);
    chk({30'h0, meas_state_o}, 32'h0);
    apb(8'h00, 1'b1, 32'h90);
    repeat (120) @(posedge pclk);
    apb(8'h00, 1'b1, 32'h12);
    repeat (20) @(negedge pclk);
    chk({31'h0, sync_oe_n}, 32'h1);
    // Local bus modes, each entered through interface reset
    for (m = 0; m < 4; m++) begin
      apb(8'h00, 1'b1, 32'hB0 | (m << 2));
      @(negedge pclk);
      chk({29'h0, lbus_rst_o, loc_ready, up_ready}, 32'h4);
      apb(8'h00, 1'b1, 32'hA0 | (m << 2));
      src = (m == 1 || m == 3) ? 16'h5555 : 16'hAAAA;
      beats(src, (m < 2) ? src : ~src);
    end
    apb(8'h00, 1'b1, 32'h8C);
    repeat (3) @(negedge pclk);
    chk({29'h0, dn_valid, up_ready, loc_ready}, 32'h0);
    apb(8'h00, 1'b0, 32'h0);
    chk(rd, 32'h8C);
    // Mid-run reset brings the control word back to its defaults
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(8'h00, 1'b0, 32'h0);
    chk(rd, 32'h90);
    complete_run;
  end
endmodule
